// *** dual_timer_defs.vh ***
`ifndef DUAL_TIMER_DEFS_VH
`define DUAL_TIMER_DEFS_VH

// Register byte addresses (index x4)
`define PRIO_IDX 16'hFF21
`define IEN_IDX 16'hFF23
`define FLAG_IDX 16'hFF25
`define OUTCTL_IDX 16'hFF30
`define T0CTL_IDX 16'hFF31
`define T1CTL_IDX 16'hFF32
`define T0RLD_IDX 16'hFF33
`define T1RLD_IDX 16'hFF34
`define T0CNT_IDX 16'hFF35
`define T1CNT_IDX 16'hFF36
`define MODE_IDX 16'hFF38
`define ADDR_W 18

// Field positions
`define PRIO_LSB 2
`define IEN_T0 6
`define IEN_T1 7
`define FLAG_T0 6
`define FLAG_T1 7
`define SEL_BIT 3
`define OEN_BIT 2
`define RUN_BIT 0
`define PSET_BIT 1
`define CONT_BIT 2
`define EVCNT_BIT 7
`define MODE16_BIT 0

// Reset values
`define RLD_RST 8'hFF
`define CNT_RST 8'hFF

`endif

// *** timer_run_sync.v ***
// Run bit held until the counter actually stops; request taken on timer clock fall, or on every cycle when bypass is set
module timer_run_sync (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Control
  input wire run_req,
  input wire tick_fall,
  input wire bypass,
  input wire oneshot_stop,
  // State
  output reg run_active_reg
);
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      run_active_reg <= 1'b0;
    else if (oneshot_stop)
      run_active_reg <= 1'b0;
    else if (bypass || tick_fall)
      run_active_reg <= run_req;
  end
endmodule

// *** dual_timer_run_output_irq.v ***
// Notes on behaviour
// RULE1: Run bit one starts, zero stops
// RULE2: Stopped counter holds value, resumes later
// RULE3: Chained mode forces timer 1 run zero
// RULE4: Run clears at reset and one-shot underflow
// RULE5: Select one picks timer 0 underflow
// RULE6: Chained mode output from 16-bit underflow
// RULE7: Enable zero keeps pin high
// RULE8: Software keeps pin data bit one
// RULE9: Two-bit field sets interrupt level
// RULE10: Per-timer enable; timer 0 ignored chained
// RULE11: Flag set with counter underflow
// RULE12: Flag sets regardless of enable, priority
// RULE13: Request when flag, enable, level above mask
// RULE14: Write one clears flag; reset zero
// RULE15: Chained mode: only timer 1 flag sets
// RULE16: Software clears flag and restores mask
// RULE17: Run change on timer clock fall
// RULE18: Event mode bypasses fall synchronisation
// RULE19: Software stops timers before sleep
// RULE20: Output gate may glitch half period
// RULE21: Software waits oscillator stabilisation
// RULE22: Software reads low byte first
// RULE23: Continuous mode reloads on underflow
// RULE24: Chained mode passes borrow to timer 1
// RULE25: Underflow updates run, flag, output together
`include "dual_timer_defs.vh"
module dual_timer_run_output_irq (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Timer input clock and event pin
  input wire timer_in_clk,
  input wire event_pin,
  // Processor interrupt mask
  input wire cpu_mask_bit_low,
  input wire cpu_mask_bit_high,
  // Interrupt request
  output reg irq_req,
  output reg [1:0] irq_level,
  // Shared output pin
  output reg shared_output_pin
);
  reg [1:0] prio_reg;
  reg timer0_irq_enable_reg;
  reg timer1_irq_enable_reg;
  reg timer0_factor_flag_reg;
  reg timer1_factor_flag_reg;
  reg output_channel_select_reg;
  reg output_enable_reg;
  reg [1:0] run_req_reg;
  reg [1:0] cont_reg;
  reg evcnt_reg;
  reg mode16_reg;
  reg [7:0] rld0_reg;
  reg [7:0] rld1_reg;
  reg [7:0] cnt0_reg;
  reg [7:0] cnt1_reg;
  reg timer_output_signal_reg;
  reg [1:0] clk_sync_reg;
  reg [1:0] evt_sync_reg;
  reg clk_prev_reg;
  reg evt_prev_reg;
  reg ph_wr_reg;
  reg ph_rd_reg;
  reg [15:0] ph_idx_reg;
  wire [1:0] run_active;
  wire tick_fall;
  wire evt_tick;
  wire [1:0] tick;
  wire [1:0] uf;
  wire uf16;
  wire [1:0] oneshot_stop;
  wire [1:0] run_req_eff;
  wire [1:0] run_read;
  wire wr_t0;
  wire wr_t1;
  wire wr_flag;
  wire t0_dec;
  wire t1_dec;
  wire [15:0] a_idx;

  // Timer clock and event pin each pass two flops before use
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_sync_reg <= 2'h0;
      evt_sync_reg <= 2'h0;
      clk_prev_reg <= 1'b0;
      evt_prev_reg <= 1'b0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[0], timer_in_clk};
      evt_sync_reg <= {evt_sync_reg[0], event_pin};
      clk_prev_reg <= clk_sync_reg[1];
      evt_prev_reg <= evt_sync_reg[1];
    end
  end
  assign tick_fall = clk_prev_reg & ~clk_sync_reg[1];
  assign evt_tick = evt_prev_reg & ~evt_sync_reg[1];
  assign tick[0] = evcnt_reg ? evt_tick : tick_fall;
  assign tick[1] = tick_fall;

  // Decrement on timer clock fall, on event pin fall for timer 0 in event mode; stop is seen after the final decrement [RULE17]
  assign t0_dec = run_active[0] & tick[0];
  assign t1_dec = mode16_reg ? (t0_dec & (cnt0_reg == 8'h00)) : (run_active[1] & tick[1]); // [RULE24]
  assign uf[0] = t0_dec & (cnt0_reg == 8'h00); // [RULE25]
  assign uf[1] = t1_dec & (cnt1_reg == 8'h00); // [RULE25]
  assign uf16 = mode16_reg & uf[1];
  assign oneshot_stop[0] = (mode16_reg ? uf16 : uf[0]) & ~cont_reg[0]; // [RULE4]
  assign oneshot_stop[1] = uf[1] & ~cont_reg[1] & ~mode16_reg; // [RULE4]
  assign run_req_eff[0] = run_req_reg[0];
  assign run_req_eff[1] = run_req_reg[1] & ~mode16_reg; // [RULE3]
  // Reads one from the run write until the counter has really stopped [RULE17]
  assign run_read = run_req_eff | run_active;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_run
      // Event counting bypasses the fall synchronisation [RULE18]
      timer_run_sync u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .run_req(run_req_eff[gi]),
        .tick_fall(tick_fall),
        .bypass(gi == 0 ? evcnt_reg : 1'b0),
        .oneshot_stop(oneshot_stop[gi]),
        .run_active_reg(run_active[gi])
      );
    end
  endgenerate

  // AHB address decode
  assign a_idx = ph_idx_reg;
  assign wr_t0 = ph_wr_reg & (a_idx == `T0CTL_IDX);
  assign wr_t1 = ph_wr_reg & (a_idx == `T1CTL_IDX);
  assign wr_flag = ph_wr_reg & (a_idx == `FLAG_IDX);

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_wr_reg <= 1'b0;
      ph_rd_reg <= 1'b0;
      ph_idx_reg <= 16'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ph_wr_reg <= hsel & hready & htrans[1] & hwrite;
      ph_rd_reg <= hsel & hready & htrans[1] & ~hwrite;
      if (hsel & hready & htrans[1])
        ph_idx_reg <= haddr[`ADDR_W-1:2];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes and counters
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prio_reg <= 2'h0;
      timer0_irq_enable_reg <= 1'b0;
      timer1_irq_enable_reg <= 1'b0;
      output_channel_select_reg <= 1'b0;
      output_enable_reg <= 1'b0;
      run_req_reg <= 2'h0;
      cont_reg <= 2'h0;
      evcnt_reg <= 1'b0;
      mode16_reg <= 1'b0;
      rld0_reg <= `RLD_RST;
      rld1_reg <= `RLD_RST;
      cnt0_reg <= `CNT_RST;
      cnt1_reg <= `CNT_RST;
    end
    else
    begin
      if (ph_wr_reg)
      begin
        case (a_idx)
          `PRIO_IDX: prio_reg <= hwdata[`PRIO_LSB+1:`PRIO_LSB]; // [RULE9]
          `IEN_IDX:
          begin
            timer0_irq_enable_reg <= hwdata[`IEN_T0]; // [RULE10]
            timer1_irq_enable_reg <= hwdata[`IEN_T1];
          end
          `OUTCTL_IDX:
          begin
            output_channel_select_reg <= hwdata[`SEL_BIT];
            output_enable_reg <= hwdata[`OEN_BIT];
          end
          `T0CTL_IDX:
          begin
            run_req_reg[0] <= hwdata[`RUN_BIT]; // [RULE1]
            cont_reg[0] <= hwdata[`CONT_BIT];
            evcnt_reg <= hwdata[`EVCNT_BIT];
          end
          `T1CTL_IDX:
          begin
            run_req_reg[1] <= hwdata[`RUN_BIT]; // [RULE1]
            cont_reg[1] <= hwdata[`CONT_BIT];
          end
          `T0RLD_IDX: rld0_reg <= hwdata[7:0];
          `T1RLD_IDX: rld1_reg <= hwdata[7:0];
          `MODE_IDX: mode16_reg <= hwdata[`MODE16_BIT];
          default:
          begin
          end
        endcase
      end
      // Hardware stop overrides the requested run level [RULE4]
      if (oneshot_stop[0])
        run_req_reg[0] <= 1'b0;
      if (oneshot_stop[1] | mode16_reg)
        run_req_reg[1] <= 1'b0; // [RULE3]
      // Preset wins; otherwise decrement, reload on underflow, else hold [RULE2]
      if (wr_t0 & hwdata[`PSET_BIT])
        cnt0_reg <= rld0_reg;
      else if (uf[0])
        cnt0_reg <= rld0_reg; // [RULE23]
      else if (t0_dec)
        cnt0_reg <= cnt0_reg - 8'h01;
      if (wr_t1 & hwdata[`PSET_BIT] & ~mode16_reg)
        cnt1_reg <= rld1_reg;
      else if (uf[1])
        cnt1_reg <= rld1_reg; // [RULE23]
      else if (t1_dec)
        cnt1_reg <= cnt1_reg - 8'h01; // [RULE24]
    end
  end

  // Factor flags: set wins over a write-one clear [RULE12]
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer0_factor_flag_reg <= 1'b0;
      timer1_factor_flag_reg <= 1'b0;
    end
    else
    begin
      if (uf[0] & ~mode16_reg)
        timer0_factor_flag_reg <= 1'b1; // [RULE11] [RULE15]
      else if (wr_flag & hwdata[`FLAG_T0])
        timer0_factor_flag_reg <= 1'b0; // [RULE14]
      if (uf[1])
        timer1_factor_flag_reg <= 1'b1; // [RULE11] [RULE15]
      else if (wr_flag & hwdata[`FLAG_T1])
        timer1_factor_flag_reg <= 1'b0; // [RULE14]
    end
  end

  // Output signal toggles on the chosen underflow; registered pin avoids gate glitches
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_output_signal_reg <= 1'b1;
      shared_output_pin <= 1'b1;
      irq_req <= 1'b0;
      irq_level <= 2'h0;
    end
    else
    begin
      if (mode16_reg ? uf[1] : (output_channel_select_reg ? uf[0] : uf[1])) // [RULE5] [RULE6]
        timer_output_signal_reg <= ~timer_output_signal_reg; // [RULE25]
      // Registered enable removes the half-period hazard of an async gate [RULE20]
      shared_output_pin <= output_enable_reg ? timer_output_signal_reg : 1'b1; // [RULE7]
      irq_level <= prio_reg; // [RULE9]
      irq_req <= (((timer0_factor_flag_reg & timer0_irq_enable_reg & ~mode16_reg) |
                   (timer1_factor_flag_reg & timer1_irq_enable_reg)) &
                  (prio_reg > {cpu_mask_bit_high, cpu_mask_bit_low})); // [RULE13] [RULE10]
    end
  end

  // Read data; run bit stays one while a start or stop is still pending [RULE17]
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (hsel & hready & htrans[1] & ~hwrite)
    begin
      case (haddr[`ADDR_W-1:2])
        `PRIO_IDX: hrdata <= {28'h0, prio_reg, 2'h0};
        `IEN_IDX: hrdata <= {24'h0, timer1_irq_enable_reg, timer0_irq_enable_reg, 6'h00};
        `FLAG_IDX: hrdata <= {24'h0, timer1_factor_flag_reg, timer0_factor_flag_reg, 6'h00};
        `OUTCTL_IDX: hrdata <= {28'h0, output_channel_select_reg, output_enable_reg, 2'h0};
        `T0CTL_IDX: hrdata <= {24'h0, evcnt_reg, 4'h0, cont_reg[0], 1'b0, run_read[0]};
        `T1CTL_IDX: hrdata <= {29'h0, cont_reg[1], 1'b0, run_read[1]};
        `T0RLD_IDX: hrdata <= {24'h0, rld0_reg};
        `T1RLD_IDX: hrdata <= {24'h0, rld1_reg};
        `T0CNT_IDX: hrdata <= {24'h0, cnt0_reg};
        `T1CNT_IDX: hrdata <= {24'h0, cnt1_reg};
        `MODE_IDX: hrdata <= {31'h0, mode16_reg};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// *** dual_timer_chk.sv ***
`include "dual_timer_defs.vh"
module dual_timer_chk (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Interrupt and pin
  input wire cpu_mask_bit_low,
  input wire cpu_mask_bit_high,
  input wire irq_req,
  input wire [1:0] irq_level,
  input wire shared_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire take = hsel && hready && htrans[1];
  reg prio_dp_reg;
  reg [1:0] prio_shadow_reg;
  // Shadow of the written priority, so the level output is tied to its bus cause
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prio_dp_reg <= 1'b0;
      prio_shadow_reg <= 2'b00;
    end
    else
    begin
      prio_dp_reg <= take && hwrite && haddr[17:2] == `PRIO_IDX;
      if (prio_dp_reg)
        prio_shadow_reg <= hwdata[`PRIO_LSB+1:`PRIO_LSB];
    end
  end
  sequence wr_phase(idx);
    take && hwrite && haddr[17:2] == idx;
  endsequence
  sequence oen_off;
    wr_phase(`OUTCTL_IDX) ##1 !hwdata[`OEN_BIT];
  endsequence
  sequence rd_low;
    take && !hwrite && haddr[17:2] < `PRIO_IDX;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  chk_rdata_stands: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  chk_unmapped_zero: assert property (rd_low |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_level_none: assert property (irq_level == 2'b00 |-> !irq_req)
    else $error("request at level zero");
  chk_above_mask: assert property
    (irq_req |-> irq_level > $past({cpu_mask_bit_high, cpu_mask_bit_low}))
    else $error("request not above mask");
  chk_prio_level: assert property
    ($stable(prio_shadow_reg) [*2] |-> irq_level == prio_shadow_reg)
    else $error("level differs from priority");
  chk_pin_off_high: assert property (oen_off |-> ##[1:3] shared_output_pin)
    else $error("pin not high when disabled");
endmodule
bind dual_timer_run_output_irq dual_timer_chk u_dual_timer_chk (.core_clk(core_clk),
  .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cpu_mask_bit_low(cpu_mask_bit_low), .cpu_mask_bit_high(cpu_mask_bit_high),
  .irq_req(irq_req), .irq_level(irq_level), .shared_output_pin(shared_output_pin));

// *** timer_clk_src.sv ***
module timer_clk_src #(parameter int half_ns = 40) (
  // Timer clock and event line
  output logic timer_in_clk,
  output logic event_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free-running and stable before any start; odd offset keeps it off the core edges
  initial
  begin
    timer_in_clk = 1'b1;
    #3;
    forever #half_ns timer_in_clk = ~timer_in_clk;
  end
  // Event line pulses on its own; only event mode counts its falls
  initial
  begin
    event_pin = 1'b1;
    #7;
    forever #30 event_pin = ~event_pin;
  end
endmodule

// *** dual_timer_run_output_irq_tb_top.sv ***
`include "dual_timer_defs.vh"
module dual_timer_run_output_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic cpu_mask_bit_low = 1'b0, cpu_mask_bit_high = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, c1;
  wire [31:0] hrdata;
  wire [1:0] irq_level;
  wire hready, hreadyout, hresp, timer_in_clk, event_pin, irq_req, shared_output_pin;
  int miscompares = 0, n_tests = 0, cyc = 0, k;
  assign hready = hreadyout;
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  timer_clk_src u_timer_clk_src (.timer_in_clk(timer_in_clk), .event_pin(event_pin));
  dual_timer_run_output_irq u_dual_timer_run_output_irq (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_in_clk(timer_in_clk), .event_pin(event_pin), .cpu_mask_bit_low(cpu_mask_bit_low),
    .cpu_mask_bit_high(cpu_mask_bit_high), .irq_req(irq_req), .irq_level(irq_level),
    .shared_output_pin(shared_output_pin));
  task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input [15:0] idx, input logic wr, input [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {14'h0, idx, 2'b00};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic rc(input [15:0] idx, input [31:0] m, input [31:0] e, input string nm);
    bus(idx, 1'b0, 32'h0);
    chk(rd & m, e, nm);
  endtask
  // Bounded polling; the design gives no completion strobe for timer events
  task automatic poll(input [15:0] idx, input [31:0] m, input [31:0] e);
    int i;
    i = 0;
    bus(idx, 1'b0, 32'h0);
    while ((rd & m) !== e && i < 100)
    begin
      bus(idx, 1'b0, 32'h0);
      i++;
    end
  endtask
  task automatic irq_is(input logic e, input string nm);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq_req}, {31'h0, e}, nm);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rc(`PRIO_IDX, 32'hC, 32'h0, "prio");
    rc(`IEN_IDX, 32'hC0, 32'h0, "ien");
    rc(`FLAG_IDX, 32'hC0, 32'h0, "flag");
    rc(`OUTCTL_IDX, 32'hC, 32'h0, "outctl");
    rc(`T0CTL_IDX, 32'h1, 32'h0, "run0");
    rc(`T1CTL_IDX, 32'h1, 32'h0, "run1");
    rc(16'hFF20, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk({31'h0, shared_output_pin}, 32'h1, "pin");
    $display("test 1 done");
    bus(`T0RLD_IDX, 1'b1, 32'h3);
    bus(`T0CTL_IDX, 1'b1, 32'h3);
    poll(`T0CTL_IDX, 32'h1, 32'h0);
    chk(rd & 32'h1, 32'h0, "oneshot run");
    rc(`FLAG_IDX, 32'hC0, 32'h40, "flag t0");
    irq_is(1'b0, "irq disabled");
    $display("test 2 done");
    bus(`IEN_IDX, 1'b1, 32'h40);
    bus(`PRIO_IDX, 1'b1, 32'h8);
    cpu_mask_bit_low <= 1'b1;
    irq_is(1'b1, "level 2 mask 1");
    cpu_mask_bit_low <= 1'b0;
    cpu_mask_bit_high <= 1'b1;
    irq_is(1'b0, "level 2 mask 2");
    cpu_mask_bit_high <= 1'b0;
    bus(`PRIO_IDX, 1'b1, 32'h0);
    irq_is(1'b0, "level 0");
    bus(`PRIO_IDX, 1'b1, 32'hC);
    bus(`FLAG_IDX, 1'b1, 32'h80);
    rc(`FLAG_IDX, 32'hC0, 32'h40, "zero write");
    irq_is(1'b1, "level 3 mask 0");
    bus(`FLAG_IDX, 1'b1, 32'h40);
    rc(`FLAG_IDX, 32'hC0, 32'h0, "w1c");
    irq_is(1'b0, "cleared");
    $display("test 3 done");
    bus(`T0RLD_IDX, 1'b1, 32'h10);
    bus(`OUTCTL_IDX, 1'b1, 32'hC); // Port data bit lies outside the block, taken as one
    bus(`T0CTL_IDX, 1'b1, 32'h7);
    for (k = 0; k < 400 && shared_output_pin === 1'b1; k++) @(posedge core_clk);
    chk({31'h0, shared_output_pin}, 32'h0, "pin fall");
    for (k = 0; k < 400 && shared_output_pin === 1'b0; k++) @(posedge core_clk);
    chk({31'h0, shared_output_pin}, 32'h1, "pin rise");
    // Stop just after a timer clock rise, so the stop is still pending when read back
    @(posedge timer_in_clk);
    bus(`T0CTL_IDX, 1'b1, 32'h4);
    rc(`T0CTL_IDX, 32'h1, 32'h1, "stop pending");
    poll(`T0CTL_IDX, 32'h1, 32'h0);
    bus(`T0CNT_IDX, 1'b0, 32'h0);
    c1 = rd;
    repeat (40) @(posedge core_clk);
    rc(`T0CNT_IDX, 32'hFF, c1 & 32'hFF, "held");
    bus(`T0CTL_IDX, 1'b1, 32'h5);
    repeat (40) @(posedge core_clk);
    bus(`T0CNT_IDX, 1'b0, 32'h0);
    chk({31'h0, rd[7:0] !== c1[7:0]}, 32'h1, "resumed");
    bus(`OUTCTL_IDX, 1'b1, 32'h8);
    repeat (3) @(posedge core_clk);
    chk({31'h0, shared_output_pin}, 32'h1, "pin off");
    // Event counting: run follows the write at once, with no timer clock fall
    bus(`T0CTL_IDX, 1'b1, 32'h87);
    repeat (40) @(posedge core_clk);
    bus(`T0CNT_IDX, 1'b0, 32'h0);
    chk({31'h0, rd[7:0] !== 8'h10}, 32'h1, "event count");
    bus(`T0CTL_IDX, 1'b1, 32'h80);
    rc(`T0CTL_IDX, 32'h81, 32'h80, "event stop");
    bus(`T0CTL_IDX, 1'b1, 32'h0);
    $display("test 4 done");
    bus(`FLAG_IDX, 1'b1, 32'hC0);
    bus(`T1RLD_IDX, 1'b1, 32'h0);
    bus(`T1CTL_IDX, 1'b1, 32'h2);
    bus(`MODE_IDX, 1'b1, 32'h1);
    bus(`T1CTL_IDX, 1'b1, 32'h1);
    rc(`T1CTL_IDX, 32'h1, 32'h0, "run1 chained");
    bus(`T0RLD_IDX, 1'b1, 32'h2);
    bus(`T0CTL_IDX, 1'b1, 32'h3);
    poll(`FLAG_IDX, 32'hC0, 32'h80);
    chk(rd & 32'hC0, 32'h80, "chained flags");
    rc(`T0CNT_IDX, 32'hFF, 32'h2, "chained low");
    rc(`T1CNT_IDX, 32'hFF, 32'h0, "chained high");
    irq_is(1'b0, "t0 enable ignored");
    bus(`IEN_IDX, 1'b1, 32'h80);
    irq_is(1'b1, "t1 request");
    $display("test 5 done");
    test_done();
  end
endmodule
